// ### core/seer_cfg.svh
`ifndef SEER_CFG_SVH
`define SEER_CFG_SVH

// ----------------------------------------------------------------
// geometry
// ----------------------------------------------------------------
`define SEER_ADDR_W        15
`define SEER_MEM_DEPTH     32768
`define SEER_PAGE_BITS     6
`define SEER_FIFO_DEPTH    2
`define SEER_CNT_RST       15'h0000
`define SEER_BYTE_BITS     4'h8
`define SEER_ACK_DONE      4'h9

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define SEER_CLK_MHZ       125
`define SEER_GLITCH_NS     50
`define SEER_GLITCH_CYC    ((`SEER_GLITCH_NS * `SEER_CLK_MHZ + 999) / 1000)
`define SEER_POR_GUARD_CYC 16

`endif

// ### core/seer_pkg.sv
package seer_pkg;

    typedef struct packed {
        logic scl;
        logic sda;
    } seer_pin_type;

    typedef logic [14:0] seer_addr_type;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_DEV,
        ST_AHI,
        ST_ALO,
        ST_WDATA,
        ST_READ
    } seer_state_type;

endpackage

// ### core/seer_read_path.sv
`timescale 1ns/100ps
`include "seer_cfg.svh"

module seer_read_path
    import seer_pkg::*;
#(
    parameter logic [3:0] DEV_TYPE      = 4'h6, // arbitrary value
    parameter int         POR_GUARD_CYC = `SEER_POR_GUARD_CYC
) (
    // clock and reset
    input  wire logic       mclk,
    input  wire logic       rstn,
    input  wire logic       ce,
    // two-wire bus
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    output logic            sda_out,
    output logic            sda_oe_n,
    // straps and status
    input  wire logic [2:0] chip_select_straps,
    output logic            busy
);

    // ----------------------------------------------------------------
    // functions
    // ----------------------------------------------------------------
    function automatic seer_addr_type lin_inc(input seer_addr_type a);
        lin_inc = a + 15'h0001;
    endfunction

    function automatic seer_addr_type page_inc(input seer_addr_type a);
        page_inc = {a[14:6], 6'(a[5:0] + 6'h01)};
    endfunction

    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    localparam logic [3:0] GLITCH_LAST = 4'(`SEER_GLITCH_CYC - 1);
    localparam logic [15:0] POR_LAST   = 16'(POR_GUARD_CYC - 1);

    seer_pin_type   sync1_ff, sync2_ff, filt_ff, prev_ff;
    logic [3:0]     flt_cnt_ff [2];
    logic [2:0]     strap1_ff, strap2_ff;
    logic [15:0]    por_cnt_ff;
    logic           por_ok_ff;
    seer_state_type state_ff;
    logic [3:0]     bit_ff;
    logic [7:0]     shreg_ff;
    logic           ackph_ff;
    logic           oe_n_ff;
    logic           busy_ff;
    logic           sda_out_ff;
    logic [6:0]     ahi_ff;
    seer_addr_type  cnt_ff;
    seer_addr_type  pf_addr_ff;
    logic           pf_on_ff;
    logic [7:0]     fifo_ff [2];
    logic           wptr_ff, rptr_ff;
    logic [1:0]     fcnt_ff;
    logic [7:0]     mem_arr [`SEER_MEM_DEPTH];

    logic scl_rise, scl_fall, ev_start, ev_stop;
    logic dev_match, ev_load, ev_push, fifo_valid, ev_wbyte, ev_alo;
    logic [7:0] load_byte;

    // ----------------------------------------------------------------
    // input sync and glitch filter
    // ----------------------------------------------------------------
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            sync1_ff  <= '1;
            sync2_ff  <= '1;
            strap1_ff <= 3'h0;
            strap2_ff <= 3'h0;
        end else if (ce) begin
            sync1_ff  <= '{scl: scl_in, sda: sda_in};
            sync2_ff  <= sync1_ff;
            strap1_ff <= chip_select_straps;
            strap2_ff <= strap1_ff;
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            filt_ff       <= '1;
            prev_ff       <= '1;
            flt_cnt_ff[0] <= 4'h0;
            flt_cnt_ff[1] <= 4'h0;
        end else if (ce) begin
            prev_ff <= filt_ff;
            for (int i = 0; i < 2; i++) begin
                if (sync2_ff[i] == filt_ff[i]) begin
                    flt_cnt_ff[i] <= 4'h0;
                end else if (flt_cnt_ff[i] == GLITCH_LAST) begin
                    filt_ff[i]    <= sync2_ff[i];
                    flt_cnt_ff[i] <= 4'h0;
                end else begin
                    flt_cnt_ff[i] <= flt_cnt_ff[i] + 4'h1;
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // power-on guard
    // ----------------------------------------------------------------
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            por_cnt_ff <= 16'h0000;
            por_ok_ff  <= 1'b0;
        end else if (ce && !por_ok_ff) begin
            if (!(filt_ff.scl && filt_ff.sda)) begin
                por_cnt_ff <= 16'h0000;
            end else if (por_cnt_ff == POR_LAST) begin
                por_ok_ff <= 1'b1;
            end else begin
                por_cnt_ff <= por_cnt_ff + 16'h0001;
            end
        end
    end

    // ----------------------------------------------------------------
    // bus events
    // ----------------------------------------------------------------
    assign scl_rise   = por_ok_ff && filt_ff.scl && !prev_ff.scl;
    assign scl_fall   = por_ok_ff && !filt_ff.scl && prev_ff.scl;
    assign ev_start   = por_ok_ff && filt_ff.scl && prev_ff.scl && prev_ff.sda && !filt_ff.sda;
    assign ev_stop    = por_ok_ff && filt_ff.scl && prev_ff.scl && !prev_ff.sda && filt_ff.sda;
    assign dev_match  = (shreg_ff[7:4] == DEV_TYPE) && (shreg_ff[3:1] == strap2_ff);
    assign fifo_valid = (fcnt_ff != 2'h0);
    assign load_byte  = fifo_valid ? fifo_ff[rptr_ff] : 8'hFF;
    assign ev_load    = ce && !ev_start && !ev_stop && scl_fall &&
                        ((state_ff == ST_DEV && ackph_ff && shreg_ff[0]) ||
                         (state_ff == ST_READ && bit_ff == `SEER_ACK_DONE));
    assign ev_wbyte   = ce && !ev_start && !ev_stop && scl_fall && ackph_ff && state_ff == ST_WDATA;
    assign ev_alo     = ce && !ev_start && !ev_stop && scl_fall && ackph_ff && state_ff == ST_ALO;
    assign ev_push    = ce && pf_on_ff && (fcnt_ff != 2'(`SEER_FIFO_DEPTH)) && !ev_start && !ev_stop;

    // ----------------------------------------------------------------
    // protocol state machine
    // ----------------------------------------------------------------
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            state_ff <= ST_IDLE;
            bit_ff   <= 4'h0;
            shreg_ff <= 8'h00;
            ackph_ff <= 1'b0;
            oe_n_ff  <= 1'b1;
        end else if (ce) begin
            if (ev_start) begin
                state_ff <= ST_DEV;
                bit_ff   <= 4'h0;
                ackph_ff <= 1'b0;
                oe_n_ff  <= 1'b1;
            end else if (ev_stop) begin
                state_ff <= ST_IDLE;
                ackph_ff <= 1'b0;
                oe_n_ff  <= 1'b1;
            end else begin
                case (state_ff)
                    ST_DEV, ST_AHI, ST_ALO, ST_WDATA: begin
                        if (scl_rise && !ackph_ff && bit_ff != `SEER_BYTE_BITS) begin
                            shreg_ff <= {shreg_ff[6:0], filt_ff.sda};
                            bit_ff   <= bit_ff + 4'h1;
                        end else if (scl_fall && !ackph_ff && bit_ff == `SEER_BYTE_BITS) begin
                            if (state_ff == ST_DEV && !dev_match) begin
                                state_ff <= ST_IDLE;
                            end else begin
                                oe_n_ff  <= 1'b0;
                                ackph_ff <= 1'b1;
                            end
                        end else if (scl_fall && ackph_ff) begin
                            ackph_ff <= 1'b0;
                            bit_ff   <= 4'h0;
                            oe_n_ff  <= 1'b1;
                            case (state_ff)
                                ST_DEV: begin
                                    if (shreg_ff[0]) begin
                                        state_ff <= ST_READ;
                                        shreg_ff <= load_byte;
                                        oe_n_ff  <= load_byte[7];
                                    end else begin
                                        state_ff <= ST_AHI;
                                    end
                                end
                                ST_AHI:  state_ff <= ST_ALO;
                                ST_ALO:  state_ff <= ST_WDATA;
                                default: state_ff <= ST_WDATA;
                            endcase
                        end
                    end
                    ST_READ: begin
                        if (scl_rise && bit_ff < `SEER_BYTE_BITS) begin
                            bit_ff <= bit_ff + 4'h1;
                        end else if (scl_rise && bit_ff == `SEER_BYTE_BITS) begin
                            if (!filt_ff.sda) begin
                                bit_ff <= `SEER_ACK_DONE;
                            end else begin
                                state_ff <= ST_IDLE;
                            end
                        end else if (scl_fall && bit_ff < `SEER_BYTE_BITS) begin
                            shreg_ff <= {shreg_ff[6:0], 1'b1};
                            oe_n_ff  <= shreg_ff[6];
                        end else if (scl_fall && bit_ff == `SEER_BYTE_BITS) begin
                            oe_n_ff <= 1'b1;
                        end else if (scl_fall && bit_ff == `SEER_ACK_DONE) begin
                            bit_ff   <= 4'h0;
                            shreg_ff <= load_byte;
                            oe_n_ff  <= load_byte[7];
                        end
                    end
                    default: begin
                        oe_n_ff  <= 1'b1;
                        ackph_ff <= 1'b0;
                    end
                endcase
            end
        end
    end

    // ----------------------------------------------------------------
    // address counter
    // ----------------------------------------------------------------
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            cnt_ff <= `SEER_CNT_RST;
            ahi_ff <= 7'h00;
        end else if (ce) begin
            if (scl_fall && ackph_ff && state_ff == ST_AHI && !ev_start && !ev_stop) begin
                ahi_ff <= shreg_ff[6:0];
            end
            if (ev_alo) begin
                cnt_ff <= {ahi_ff, shreg_ff};
            end else if (ev_wbyte) begin
                cnt_ff <= page_inc(cnt_ff);
            end else if (ev_load) begin
                cnt_ff <= lin_inc(cnt_ff);
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (ev_wbyte) begin
            mem_arr[cnt_ff] <= shreg_ff;
        end
    end

    // ----------------------------------------------------------------
    // prefetch buffer
    // ----------------------------------------------------------------
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            pf_on_ff   <= 1'b0;
            pf_addr_ff <= `SEER_CNT_RST;
            wptr_ff    <= 1'b0;
            rptr_ff    <= 1'b0;
            fcnt_ff    <= 2'h0;
            fifo_ff[0] <= 8'h00;
            fifo_ff[1] <= 8'h00;
        end else if (ce) begin
            if (ev_start || ev_stop || (state_ff == ST_IDLE)) begin
                pf_on_ff <= 1'b0;
                wptr_ff  <= 1'b0;
                rptr_ff  <= 1'b0;
                fcnt_ff  <= 2'h0;
            end else if (state_ff == ST_DEV && scl_fall && !ackph_ff &&
                         bit_ff == `SEER_BYTE_BITS && dev_match && shreg_ff[0]) begin
                pf_on_ff   <= 1'b1;
                pf_addr_ff <= cnt_ff;
            end else begin
                if (ev_push) begin
                    fifo_ff[wptr_ff] <= mem_arr[pf_addr_ff];
                    wptr_ff          <= ~wptr_ff;
                    pf_addr_ff       <= lin_inc(pf_addr_ff);
                end
                if (ev_load && fifo_valid) begin
                    rptr_ff <= ~rptr_ff;
                end
                fcnt_ff <= 2'(fcnt_ff + 2'(ev_push) - 2'(ev_load && fifo_valid));
            end
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            busy_ff    <= 1'b0;
            sda_out_ff <= 1'b0;
        end else if (ce) begin
            busy_ff    <= (state_ff != ST_IDLE);
            sda_out_ff <= 1'b0;
        end
    end

    assign sda_oe_n = oe_n_ff;
    assign sda_out  = sda_out_ff;
    assign busy     = busy_ff;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);

    a_idle_released: assert property (state_ff == ST_IDLE |-> oe_n_ff)
        else $error("bus driven while in standby");
    a_por_blocks_bus: assert property (!por_ok_ff |-> state_ff == ST_IDLE && oe_n_ff)
        else $error("bus activity before power-on guard released");
    a_filter_width: assert property ((filt_ff.sda != prev_ff.sda) |->
                                     $past(flt_cnt_ff[0]) == GLITCH_LAST)
        else $error("data line filter passed a short pulse");
    a_seq_wrap_zero: assert property (ev_load && cnt_ff == 15'h7FFF |=> cnt_ff == 15'h0000)
        else $error("counter did not wrap to zero after top address");
    a_load_increment: assert property (ev_load |=> cnt_ff == $past(cnt_ff) + 15'h0001)
        else $error("counter not advanced after byte loaded");
    a_page_wrap: assert property (ev_wbyte && cnt_ff[5:0] == 6'h3F |=>
                                  cnt_ff[5:0] == 6'h00 && $stable(cnt_ff[14:6]))
        else $error("write counter carried out of page");
    a_random_load: assert property (ev_alo |=> cnt_ff == {$past(ahi_ff), $past(shreg_ff)})
        else $error("address counter not loaded by dummy write");
    a_mismatch_noack: assert property (ce && !ev_start && !ev_stop && state_ff == ST_DEV && scl_fall &&
                                       !ackph_ff && bit_ff == 4'h8 && !dev_match
                                       |=> state_ff == ST_IDLE && oe_n_ff)
        else $error("acknowledged a foreign address word");
    a_match_ack: assert property (ce && !ev_start && !ev_stop && state_ff == ST_DEV && scl_fall &&
                                  !ackph_ff && bit_ff == 4'h8 && dev_match
                                  |=> !oe_n_ff && ackph_ff)
        else $error("matching address word not acknowledged");
    a_nack_standby: assert property (ce && !ev_start && !ev_stop && state_ff == ST_READ && scl_rise &&
                                     bit_ff == 4'h8 && filt_ff.sda |=> state_ff == ST_IDLE)
        else $error("read continued after no-acknowledge");
    a_fifo_bound: assert property (fcnt_ff != 2'h3 && (!ev_load || fifo_valid))
        else $error("byte loaded from empty prefetch buffer");

    c_random_read:  cover property (ev_alo ##[1:1000] (state_ff == ST_READ));
    c_seq_wrap:     cover property (ev_load && cnt_ff == 15'h7FFF);
    c_fifo_full:    cover property (fcnt_ff == 2'h2);
    c_nack_end:     cover property (state_ff == ST_READ ##1 state_ff == ST_IDLE);

endmodule // seer_read_path

// ### verification/seer_host_model.sv
`timescale 1ns/100ps

// ----------------------------------------------------------------
// bus master model, lines change only on mclk rising edges
// ----------------------------------------------------------------
module seer_host_model
    import seer_pkg::*;
#(
    parameter int Q = 16
) (
    // clock
    input  wire logic   mclk,
    // bus
    input  wire logic   sda_line,
    output seer_pin_type drv_ff
);
    // lines rest high outside frames, no edges during supply ramps
    initial drv_ff = '{scl: 1'b1, sda: 1'b1};

    task automatic wq(input int n);
        repeat (n) @(posedge mclk);
    endtask

    // one bit; sda changes only while scl is low, sampled at end of high
    task automatic put_bit(input logic b, output logic got);
        wq(Q);
        drv_ff.sda <= b;
        wq(Q);
        drv_ff.scl <= 1'b1;
        wq(2 * Q);
        got = sda_line;
        drv_ff.scl <= 1'b0;
    endtask

    // start or repeated start
    task automatic start_c();
        wq(Q);
        drv_ff.sda <= 1'b1;
        wq(Q);
        drv_ff.scl <= 1'b1;
        wq(Q);
        drv_ff.sda <= 1'b0;
        wq(Q);
        drv_ff.scl <= 1'b0;
    endtask

    task automatic stop_c();
        wq(Q);
        drv_ff.sda <= 1'b0;
        wq(Q);
        drv_ff.scl <= 1'b1;
        wq(Q);
        drv_ff.sda <= 1'b1;
        wq(Q);
    endtask

    // byte out msb first, returns the device's acknowledge
    task automatic send_byte(input logic [7:0] b, output logic ack);
        logic x;
        for (int i = 7; i >= 0; i--) begin
            put_bit(b[i], x);
        end
        put_bit(1'b1, ack);
    endtask

    // byte in with sda released, then our acknowledge
    task automatic recv_byte(input logic nack, output logic [7:0] d);
        logic x;
        for (int i = 7; i >= 0; i--) begin
            put_bit(1'b1, d[i]);
        end
        put_bit(nack, x);
    endtask

    // short low pulse on sda while idle
    task automatic glitch(input int n);
        drv_ff.sda <= 1'b0;
        wq(n);
        drv_ff.sda <= 1'b1;
    endtask
endmodule // seer_host_model

// ### verification/seer_read_path_tb.sv
`timescale 1ns/100ps

module seer_read_path_tb;
    import seer_pkg::*;

    localparam logic [3:0] DEV_TYPE = 4'h6; // arbitrary value

    logic         mclk;
    logic         rstn;
    logic         ce;
    logic [2:0]   straps;
    seer_pin_type drv;
    logic         sda_out;
    logic         sda_oe_n;
    logic         busy;
    logic         sda_w;
    int           err_count;
    int           n_checks;
    int           cnt;
    logic [7:0]   mem [int];

    // open-drain wire with pull-up
    assign sda_w = drv.sda & (sda_oe_n | sda_out);

    seer_read_path #(.DEV_TYPE(DEV_TYPE), .POR_GUARD_CYC(16)) seer_read_path_i (
        .mclk               (mclk),
        .rstn               (rstn),
        .ce                 (ce),
        .scl_in             (drv.scl),
        .sda_in             (sda_w),
        .sda_out            (sda_out),
        .sda_oe_n           (sda_oe_n),
        .chip_select_straps (straps),
        .busy               (busy)
    );

    seer_host_model #(.Q(16)) seer_host_model_i (
        .mclk     (mclk),
        .sda_line (sda_w),
        .drv_ff   (drv)
    );

    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    // ----------------------------------------------------------------
    // reporting
    // ----------------------------------------------------------------
    task automatic results();
        $display("checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    initial begin
        repeat (90000) @(posedge mclk);
        err_count++;
        $display("BAD %0t run limit reached", $time);
        results();
    end

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    task automatic idle_chk(input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge mclk);
            chk({7'h00, busy}, 8'h00, "busy while idle");
        end
    endtask

    task automatic wait_idle();
        int i;
        for (i = 0; i < 200 && busy !== 1'b0; i++) begin
            @(posedge mclk);
        end
        chk({7'h00, busy}, 8'h00, "standby after stop");
        if (busy !== 1'b0) begin
            results();
        end
    endtask

    task automatic addr_phase(input logic [15:0] a);
        logic ack;
        seer_host_model_i.start_c();
        seer_host_model_i.send_byte({DEV_TYPE, straps, 1'b0}, ack);
        chk({7'h00, ack}, 8'h00, "write word ack");
        seer_host_model_i.send_byte(a[15:8], ack);
        chk({7'h00, ack}, 8'h00, "addr hi ack");
        seer_host_model_i.send_byte(a[7:0], ack);
        chk({7'h00, ack}, 8'h00, "addr lo ack");
    endtask

    task automatic wr(input logic [15:0] a, input int n);
        logic       ack;
        logic [7:0] d;
        int         p;
        addr_phase(a);
        p = int'(a[14:0]);
        for (int i = 0; i < n; i++) begin
            d = 8'($urandom);
            seer_host_model_i.send_byte(d, ack);
            chk({7'h00, ack}, 8'h00, "data ack");
            mem[p] = d;
            p = (p & 'h7FC0) | ((p + 1) & 'h3F);
        end
        cnt = p;
        seer_host_model_i.stop_c();
        wait_idle();
    endtask

    task automatic rd(input bit rnd, input logic [15:0] a, input int n);
        logic       ack;
        logic [7:0] d;
        if (rnd) begin
            addr_phase(a);
            cnt = int'(a[14:0]);
        end
        seer_host_model_i.start_c();
        seer_host_model_i.send_byte({DEV_TYPE, straps, 1'b1}, ack);
        chk({7'h00, ack}, 8'h00, "read word ack");
        chk({7'h00, busy}, 8'h01, "busy during read");
        for (int i = 0; i < n; i++) begin
            seer_host_model_i.recv_byte(i == n - 1, d);
            chk(d, mem[cnt], "read byte");
            cnt = (cnt + 1) & 'h7FFF;
            if (i == 1) begin
                ce <= 1'b0;
                seer_host_model_i.wq(100);
                ce <= 1'b1;
                seer_host_model_i.wq(200);
            end
        end
        seer_host_model_i.stop_c();
        wait_idle();
    endtask

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        logic       ack;
        logic [7:0] bad [2];
        rstn = 1'b0;
        ce = 1'b1;
        straps = 3'h0;
        err_count = 0;
        n_checks = 0;
        cnt = 0;
        void'($urandom(80));
        @(posedge mclk);
        straps <= 3'($urandom);
        repeat (8) @(posedge mclk);
        rstn <= 1'b1;
        repeat (3) @(posedge mclk);
        seer_host_model_i.glitch(12);
        idle_chk(60);
        seer_host_model_i.glitch(4);
        idle_chk(40);
        wr(16'h0000, 4);
        wr(16'h003E, 3);
        rd(1'b0, 16'h0000, 1);
        wr(16'h7FFE, 2);
        rd(1'b1, 16'hFFFE, 4);
        rd(1'b1, 16'h7FFF, 1);
        rd(1'b0, 16'h0000, 2);
        bad[0] = {DEV_TYPE ^ 4'h8, straps, 1'b1};
        bad[1] = {DEV_TYPE, straps ^ 3'h1, 1'b1};
        foreach (bad[k]) begin
            seer_host_model_i.start_c();
            seer_host_model_i.send_byte(bad[k], ack);
            chk({7'h00, ack}, 8'h01, "foreign word refused");
            seer_host_model_i.stop_c();
            wait_idle();
        end
        rd(1'b0, 16'h0000, 1);
        results();
    end
endmodule // seer_read_path_tb
